/* File: inc/msd_defines.vh */
// address map, reset values and field positions for the memory space decoder
`ifndef MSD_DEFINES_VH
`define MSD_DEFINES_VH

`define MSD_PROG_BYTES      4096
`define MSD_PROG_AW         12
`define MSD_RESET_PC        16'h0000
`define MSD_VEC_BASE        16'h0003
`define MSD_VEC_STEP        16'h0008
`define MSD_RAM_BYTES       256
`define MSD_BANK_TOP        8'h1F
`define MSD_BIT_RAM_BASE    8'h20
`define MSD_UPPER_BASE      8'h80

`define MSD_ADDR_SP         8'h81
`define MSD_ADDR_PTR0_LO    8'h82
`define MSD_ADDR_PTR0_HI    8'h83
`define MSD_ADDR_PTR1_LO    8'h84
`define MSD_ADDR_PTR1_HI    8'h85
`define MSD_ADDR_WDT        8'h8E
`define MSD_ADDR_EXT_OP     8'hA2
`define MSD_ADDR_PSW        8'hD0

`define MSD_RST_SP          8'h07
`define MSD_RST_ZERO        8'h00
`define MSD_RST_WDT_DATA    8'hFF
`define MSD_EXT_OP_MASK     8'h17
`define MSD_PSW_RS_LSB      3

`define MSD_EXT_LO          16'h1000
`define MSD_EXT_HI          16'h505F
`define MSD_EE_LO           16'h6000
`define MSD_EE_HI           16'h607F

`define MSD_SP_BANK1        3'h0
`define MSD_SP_DIRECT       3'h1
`define MSD_SP_RAM          3'h2
`define MSD_SP_SFR          3'h3
`define MSD_SP_EXTENDED_REGISTER_AREA         3'h4
`define MSD_SP_EE           3'h5
`define MSD_SP_NONE         3'h7

`endif

/* File: logic/msd_bit_map.v */
// bit-address to byte-address and bit-index translation
`timescale 1ns/1ps
`include "msd_defines.vh"

module msd_bit_map (
    input  wire [7:0] bit_addr_i,
    output wire [7:0] byte_addr_o,
    output wire [2:0] bit_idx_o
);
    // low half lands in the bit-addressable ram, high half on sfr rows ending 0h/8h
    assign byte_addr_o = bit_addr_i[7] ? {bit_addr_i[7:3], 3'h0}
                                       : (`MSD_BIT_RAM_BASE + {4'h0, bit_addr_i[6:3]});
    assign bit_idx_o   = bit_addr_i[2:0];
endmodule

/* File: logic/msd_space_decoder.v */
// memory space decoder: program fetch, internal ram, special registers
`timescale 1ns/1ps
`include "msd_defines.vh"
//
// Overview of operation
// [RQ1] the fetch address is 16 bits but only the low 4 Kbytes are decoded as program memory.
// [RQ2] after reset the fetch address sits at zero so the first fetch is from address zero.
// [RQ3] every interrupt source vectors to a fixed slot, base 0x03 plus eight bytes per source.
// [RQ4] unused vector slots are plain program memory with no special decoding.
// [RQ5] program and data are separate spaces, data uses 8-bit addresses and 16-bit ones come from the data pointer.
// [RQ6] internal ram holds 256 bytes and the stack lives in it.
// [RQ7] for 0x80 to 0xFF direct access picks the special registers and indirect access picks upper ram.
// [RQ8] the lowest 32 ram bytes are four banks of eight registers chosen by two status word bits.
// [RQ9] the 16 bytes above the banks are bit addressable as bit addresses 0x00 to 0x7F.
// [RQ10] lower 128 bytes take direct and indirect access, upper 128 only indirect.
// [RQ11] special registers whose address ends in 0x0 or 0x8 are also bit addressable.
// [RQ12] the extended register area is a separate byte-wide readable and writable space.
// [RQ13] the eeprom window is read through the data pointer and never written by direct store.
// [RQ14] address 0x8E writes the watchdog data register and reads the watchdog counter.
// [RQ15] reserved register addresses read zero and ignore writes.

module msd_space_decoder (
    input  wire        ref_clk_i,
    input  wire        rst_i,
    // program fetch
    input  wire [15:0] pc_i,
    input  wire        pc_load_i,
    input  wire [15:0] pc_load_val_i,
    input  wire        pc_inc_i,
    input  wire        irq_take_i,
    input  wire [3:0]  irq_src_i,
    output wire [15:0] fetch_addr_o,
    output wire        prog_sel_o,
    output wire [11:0] prog_addr_o,
    // internal data access
    input  wire        dacc_i,
    input  wire        dwr_i,
    input  wire        dind_i,
    input  wire        dbit_i,
    input  wire        dbank_i,
    input  wire [7:0]  daddr_i,
    input  wire [7:0]  dwdata_i,
    input  wire        dbit_val_i,
    output reg  [7:0]  drdata_o,
    output reg         dbit_rd_o,
    output reg  [2:0]  dspace_o,
    // 16-bit data pointer access
    input  wire        xacc_i,
    input  wire        xwr_i,
    input  wire [7:0]  xwdata_i,
    output wire [15:0] data_pointer_o,
    output reg         ext_area_sel_o,
    output reg         ext_area_wr_o,
    output reg         ee_sel_o,
    output wire [7:0]  xwdata_o,
    input  wire [7:0]  ext_area_rdata_i,
    input  wire [7:0]  ee_rdata_i,
    output reg  [7:0]  xrdata_o,
    output reg         ee_store_err_o,
    // peripheral special register bus and watchdog
    output reg         sfr_ext_sel_o,
    output reg         sfr_ext_wr_o,
    output wire [7:0]  sfr_ext_addr_o,
    output wire [7:0]  sfr_ext_wdata_o,
    input  wire        sfr_ext_hit_i,
    input  wire [7:0]  sfr_ext_rdata_i,
    input  wire [7:0]  watchdog_count_reg_i,
    output wire [7:0]  watchdog_data_reg_o,
    output reg         watchdog_data_wr_o,
    // register contents
    output wire [7:0]  stack_pointer_o,
    output wire [7:0]  program_status_word_o,
    output wire [1:0]  bank_sel_o,
    output wire        trap_en_o
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [15:0] pc_r;
    reg [7:0]  stack_pointer_r;
    reg [7:0]  data_pointer_low_r;
    reg [7:0]  data_pointer_high_r;
    reg [7:0]  second_pointer_low_r;
    reg [7:0]  second_pointer_high_r;
    reg [7:0]  extended_operation_r;
    reg [7:0]  program_status_word_r;
    reg [7:0]  watchdog_data_reg_r;
    reg [7:0]  internal_ram [0:`MSD_RAM_BYTES-1];

    // ------------------------------------------------------------
    // program counter and fetch decode
    // ------------------------------------------------------------
    wire [15:0] vec_addr = `MSD_VEC_BASE + {9'h000, irq_src_i, 3'h0};

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            pc_r <= `MSD_RESET_PC; // RQ2
        end else if (irq_take_i) begin
            pc_r <= vec_addr; // RQ3
        end else if (pc_load_i) begin
            pc_r <= pc_load_val_i;
        end else if (pc_inc_i) begin
            pc_r <= pc_r + 16'h0001;
        end
    end

    // pc_i is ORed with our counter to form the fetch address; tie to zero to use ours
    assign fetch_addr_o = pc_r | pc_i;
    // vector slots are not special here, so unused ones fetch as normal code
    assign prog_sel_o   = (fetch_addr_o[15:`MSD_PROG_AW] == 4'h0); // RQ1 RQ4
    assign prog_addr_o  = fetch_addr_o[`MSD_PROG_AW-1:0]; // RQ1

    // ------------------------------------------------------------
    // data space decode
    // ------------------------------------------------------------
    wire [1:0] bank_sel = program_status_word_r[`MSD_PSW_RS_LSB+1:`MSD_PSW_RS_LSB];
    wire [7:0] bit_byte;
    wire [2:0] bit_idx;

    msd_bit_map u_bit_map (
        .bit_addr_i  (daddr_i),
        .byte_addr_o (bit_byte),
        .bit_idx_o   (bit_idx)
    );

    reg  [7:0] eff_addr;
    reg        to_ram;
    reg        to_sfr;
    always @* begin
        eff_addr = daddr_i;
        to_ram   = 1'b0;
        to_sfr   = 1'b0;
        if (dbank_i) begin
            eff_addr = {3'h0, bank_sel, daddr_i[2:0]}; // RQ8
            to_ram   = 1'b1;
        end else if (dbit_i) begin
            eff_addr = bit_byte; // RQ9 RQ11
            to_ram   = ~bit_byte[7];
            to_sfr   = bit_byte[7];
        end else if (daddr_i < `MSD_UPPER_BASE) begin
            to_ram   = 1'b1; // RQ10
        end else if (dind_i) begin
            to_ram   = 1'b1; // RQ7 RQ10
        end else begin
            to_sfr   = 1'b1; // RQ7
        end
    end

    // which internal register the decoded sfr address names
    wire loc_sp     = to_sfr && eff_addr == `MSD_ADDR_SP;
    wire loc_p0_lo  = to_sfr && eff_addr == `MSD_ADDR_PTR0_LO;
    wire loc_p0_hi  = to_sfr && eff_addr == `MSD_ADDR_PTR0_HI;
    wire loc_p1_lo  = to_sfr && eff_addr == `MSD_ADDR_PTR1_LO;
    wire loc_p1_hi  = to_sfr && eff_addr == `MSD_ADDR_PTR1_HI;
    wire loc_ext_op = to_sfr && eff_addr == `MSD_ADDR_EXT_OP;
    wire loc_psw    = to_sfr && eff_addr == `MSD_ADDR_PSW;
    wire loc_wdt    = to_sfr && eff_addr == `MSD_ADDR_WDT;
    wire loc_any    = loc_sp | loc_p0_lo | loc_p0_hi | loc_p1_lo | loc_p1_hi | loc_ext_op | loc_psw | loc_wdt;

    // current byte of the selected sfr, before bit merge
    reg [7:0] sfr_byte;
    always @* begin
        sfr_byte = 8'h00; // RQ15
        if (loc_sp) begin
            sfr_byte = stack_pointer_r;
        end else if (loc_p0_lo) begin
            sfr_byte = data_pointer_low_r;
        end else if (loc_p0_hi) begin
            sfr_byte = data_pointer_high_r;
        end else if (loc_p1_lo) begin
            sfr_byte = second_pointer_low_r;
        end else if (loc_p1_hi) begin
            sfr_byte = second_pointer_high_r;
        end else if (loc_ext_op) begin
            sfr_byte = extended_operation_r;
        end else if (loc_psw) begin
            sfr_byte = program_status_word_r;
        end else if (loc_wdt) begin
            sfr_byte = watchdog_count_reg_i; // RQ14
        end else if (sfr_ext_hit_i) begin
            sfr_byte = sfr_ext_rdata_i;
        end
    end

    wire [7:0] ram_byte = internal_ram[eff_addr];
    wire [7:0] cur_byte = to_ram ? ram_byte : sfr_byte;
    reg  [7:0] bit_merged;
    always @* begin
        bit_merged          = cur_byte;
        bit_merged[bit_idx] = dbit_val_i;
    end
    wire [7:0] wr_byte = dbit_i ? bit_merged : dwdata_i;
    wire       wr_en   = dacc_i & dwr_i;

    // ------------------------------------------------------------
    // internal ram, stack included
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (wr_en && to_ram) begin
            internal_ram[eff_addr] <= wr_byte; // RQ6
        end
    end

    // ------------------------------------------------------------
    // core special registers
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            stack_pointer_r       <= `MSD_RST_SP;
            data_pointer_low_r    <= `MSD_RST_ZERO;
            data_pointer_high_r   <= `MSD_RST_ZERO;
            second_pointer_low_r  <= `MSD_RST_ZERO;
            second_pointer_high_r <= `MSD_RST_ZERO;
            extended_operation_r  <= `MSD_RST_ZERO;
            program_status_word_r <= `MSD_RST_ZERO;
            watchdog_data_reg_r   <= `MSD_RST_WDT_DATA;
        end else if (wr_en) begin
            if (loc_sp) begin
                stack_pointer_r <= wr_byte;
            end
            if (loc_p0_lo) begin
                data_pointer_low_r <= wr_byte;
            end
            if (loc_p0_hi) begin
                data_pointer_high_r <= wr_byte;
            end
            if (loc_p1_lo) begin
                second_pointer_low_r <= wr_byte;
            end
            if (loc_p1_hi) begin
                second_pointer_high_r <= wr_byte;
            end
            if (loc_ext_op) begin
                // unused bits stay zero
                extended_operation_r <= wr_byte & `MSD_EXT_OP_MASK; // RQ15
            end
            if (loc_psw) begin
                program_status_word_r <= wr_byte;
            end
            if (loc_wdt) begin
                watchdog_data_reg_r <= wr_byte; // RQ14
            end
        end
    end

    // ------------------------------------------------------------
    // data read path and outward strobes
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            drdata_o  <= 8'h00;
            dbit_rd_o <= 1'b0;
            dspace_o  <= `MSD_SP_NONE;
        end else if (dacc_i && !dwr_i) begin
            drdata_o  <= cur_byte;
            dbit_rd_o <= cur_byte[bit_idx];
            if (dbank_i) begin
                dspace_o <= `MSD_SP_BANK1;
            end else if (to_ram) begin
                dspace_o <= (daddr_i < `MSD_UPPER_BASE) ? `MSD_SP_DIRECT : `MSD_SP_RAM;
            end else begin
                dspace_o <= `MSD_SP_SFR;
            end
        end
    end

    always @* begin
        sfr_ext_sel_o      = dacc_i & to_sfr & ~loc_any;
        sfr_ext_wr_o       = wr_en & to_sfr & ~loc_any;
        watchdog_data_wr_o = wr_en & loc_wdt; // RQ14
    end
    assign sfr_ext_addr_o  = eff_addr;
    assign sfr_ext_wdata_o = wr_byte;

    // ------------------------------------------------------------
    // 16-bit data pointer window: extended registers and eeprom
    // ------------------------------------------------------------
    // selector code 1 picks the second pointer; reserved codes fall back to the first
    wire   use_second = (extended_operation_r[2:0] == 3'h1);
    assign data_pointer_o = use_second ? {second_pointer_high_r, second_pointer_low_r}
                                       : {data_pointer_high_r, data_pointer_low_r}; // RQ5
    wire   hit_ext  = data_pointer_o >= `MSD_EXT_LO && data_pointer_o <= `MSD_EXT_HI;
    wire   hit_ee   = data_pointer_o >= `MSD_EE_LO && data_pointer_o <= `MSD_EE_HI;
    assign xwdata_o = xwdata_i;

    always @* begin
        ext_area_sel_o = xacc_i & hit_ext; // RQ12
        ext_area_wr_o  = xacc_i & xwr_i & hit_ext; // RQ12
        ee_sel_o       = xacc_i & ~xwr_i & hit_ee; // RQ13
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            xrdata_o       <= 8'h00;
            ee_store_err_o <= 1'b0;
        end else begin
            // a direct store into the eeprom window is dropped and flagged
            ee_store_err_o <= xacc_i & xwr_i & hit_ee; // RQ13
            if (xacc_i && !xwr_i) begin
                if (hit_ext) begin
                    xrdata_o <= ext_area_rdata_i;
                end else if (hit_ee) begin
                    xrdata_o <= ee_rdata_i; // RQ13
                end else begin
                    xrdata_o <= 8'h00; // RQ15
                end
            end
        end
    end

    // ------------------------------------------------------------
    // register views
    // ------------------------------------------------------------
    assign stack_pointer_o       = stack_pointer_r;
    assign program_status_word_o = program_status_word_r;
    assign bank_sel_o            = bank_sel;
    assign trap_en_o             = extended_operation_r[4];
    assign watchdog_data_reg_o   = watchdog_data_reg_r;

endmodule

/* File: sim/msd_space_decoder_monitor.sv */
// assertion checker for the memory space decoder
`timescale 1ns/1ps
module msd_space_decoder_monitor (
    input wire        ref_clk_i,
    input wire        rst_i,
    input wire [15:0] pc_i,
    input wire        pc_load_i,
    input wire        pc_inc_i,
    input wire        irq_take_i,
    input wire [3:0]  irq_src_i,
    input wire [15:0] fetch_addr_o,
    input wire        prog_sel_o,
    input wire [11:0] prog_addr_o,
    input wire        dacc_i,
    input wire        dwr_i,
    input wire        dind_i,
    input wire        dbit_i,
    input wire        dbank_i,
    input wire [7:0]  daddr_i,
    input wire [7:0]  dwdata_i,
    input wire [7:0]  drdata_o,
    input wire [2:0]  dspace_o,
    input wire [7:0]  stack_pointer_o,
    input wire        xacc_i,
    input wire        xwr_i,
    input wire        ee_sel_o,
    input wire        ee_store_err_o,
    input wire [15:0] data_pointer_o,
    input wire [7:0]  watchdog_count_reg_i,
    input wire [7:0]  watchdog_data_reg_o,
    input wire        watchdog_data_wr_o
);
    wire rd_w = dacc_i && !dwr_i && !dbit_i && !dbank_i;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // ----
    // space selection and fetch
    // ----
    sp_read_a: assert property (rd_w && !dind_i && daddr_i == 8'h81 |=> drdata_o == stack_pointer_o)
        else $error("stack pointer read wrong");
    sfr_dir_a: assert property (rd_w && !dind_i && daddr_i inside {[8'h81:8'h85]} |=> dspace_o == 3'h3)
        else $error("direct high read not in register space");
    upper_ind_a: assert property (rd_w && dind_i && daddr_i[7] |=> dspace_o == 3'h2)
        else $error("indirect high read not in upper ram");
    prog_sel_a: assert property (prog_sel_o == (fetch_addr_o < 16'h1000) && prog_addr_o == fetch_addr_o[11:0])
        else $error("program select wrong");
    vec_addr_a: assert property (irq_take_i && !pc_load_i && !pc_inc_i && pc_i == 16'h0
        |=> fetch_addr_o == 16'h0003 + {9'h0, $past(irq_src_i), 3'h0}) else $error("vector address wrong");
    rst_pc_a: assert property ($fell(rst_i) && pc_i == 16'h0 |-> fetch_addr_o == 16'h0000)
        else $error("fetch not at zero after reset");
    wdt_wr_a: assert property (watchdog_data_wr_o |=> watchdog_data_reg_o == $past(dwdata_i))
        else $error("watchdog data not loaded");
    wdt_rd_a: assert property (rd_w && !dind_i && daddr_i == 8'h8E |=> drdata_o == $past(watchdog_count_reg_i))
        else $error("watchdog counter read wrong");
    // the read select stays low on stores, so the window is decoded from the pointer itself
    ee_err_a: assert property (xacc_i && xwr_i && data_pointer_o inside {[16'h6000:16'h607F]}
        |=> ee_store_err_o) else $error("eeprom store not flagged");
    cover property (watchdog_data_wr_o);
    cover property (irq_take_i);
    cover property (ee_store_err_o);
endmodule

bind msd_space_decoder msd_space_decoder_monitor mon_u (.*);

/* File: sim/msd_periph_model.sv */
// peripheral side model: extended area, eeprom window and watchdog counter
`timescale 1ns/1ps
module msd_periph_model #(
    parameter [7:0] WDT_CNT = 8'h3C
) (
    input  wire        ref_clk_i,
    input  wire [15:0] ptr_i,
    input  wire        esel_i,
    output wire        hit_o,
    output wire [7:0]  srd_o,
    output wire [7:0]  xrd_o,
    output wire [7:0]  erd_o,
    output wire [7:0]  wcnt_o
);
    reg [7:0] tog_r = 8'h5A;
    // unclaimed data flips every cycle so a stale capture cannot pass
    always @(posedge ref_clk_i) tog_r <= ~tog_r;
    assign hit_o  = 1'b0;
    assign srd_o  = tog_r;
    assign xrd_o  = ptr_i[7:0] ^ 8'h5A;
    assign erd_o  = esel_i ? ~ptr_i[7:0] : tog_r;
    assign wcnt_o = WDT_CNT;
endmodule

/* File: sim/msd_space_decoder_tb.sv */
// self-checking bench for the memory space decoder
`timescale 1ns/1ps
module msd_space_decoder_tb;
    localparam [7:0] WCNT = 8'h3C;
    logic        ref_clk_i = 0, rst_i = 1, pc_load_i = 0, pc_inc_i = 0, irq_take_i = 0, dacc_i = 0, dwr_i = 0;
    logic        dind_i = 0, dbit_i = 0, dbank_i = 0, dbit_val_i = 0, xacc_i = 0, xwr_i = 0, rdp = 0;
    logic [15:0] pc_i = 0, pc_load_val_i = 0;
    logic [3:0]  irq_src_i = 0;
    logic [7:0]  daddr_i = 0, dwdata_i = 0, xwdata_i = 0, v;
    logic [9:0]  me, q[$];
    wire  [15:0] fetch_addr_o, data_pointer_o;
    wire  [11:0] prog_addr_o;
    wire  [7:0]  drdata_o, xrdata_o, xwdata_o, sfr_ext_addr_o, sfr_ext_wdata_o, watchdog_data_reg_o, stack_pointer_o;
    wire  [7:0]  program_status_word_o, ext_area_rdata_i, ee_rdata_i, sfr_ext_rdata_i, watchdog_count_reg_i;
    wire  [2:0]  dspace_o;
    wire  [1:0]  bank_sel_o;
    wire         prog_sel_o, dbit_rd_o, ext_area_sel_o, ext_area_wr_o, ee_sel_o, ee_store_err_o, sfr_ext_sel_o;
    wire         sfr_ext_wr_o, sfr_ext_hit_i, watchdog_data_wr_o, trap_en_o;
    int          err_total = 0, n_checks = 0, i;

    msd_space_decoder dut_u (.*);
    msd_periph_model #(.WDT_CNT(WCNT)) per_u (.ref_clk_i(ref_clk_i), .ptr_i(data_pointer_o), .esel_i(ee_sel_o),
        .hit_o(sfr_ext_hit_i), .srd_o(sfr_ext_rdata_i), .xrd_o(ext_area_rdata_i), .erd_o(ee_rdata_i),
        .wcnt_o(watchdog_count_reg_i));

    task chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task acc(input logic w, ind, b, bk, input logic [7:0] a, d);
        @(negedge ref_clk_i);
        {dacc_i, xacc_i, dwr_i, dind_i, dbit_i, dbank_i, daddr_i, dwdata_i, dbit_val_i} = {2'b10, w, ind, b, bk, a, d, d[0]};
        #1;
    endtask
    task rd(input logic ind, b, bk, input logic [7:0] a, input logic [9:0] e);
        acc(0, ind, b, bk, a, 0);
        q.push_back(e);
    endtask
    task xa(input logic w, input logic [7:0] d, input logic [9:0] e);
        @(negedge ref_clk_i);
        {dacc_i, xacc_i, xwr_i, xwdata_i} = {2'b01, w, d};
        if (!w) q.push_back(e);
        #1;
    endtask
    task idle;
        @(negedge ref_clk_i);
        {dacc_i, xacc_i, pc_load_i, pc_inc_i, irq_take_i} = 0;
        #1;
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial forever #50 ref_clk_i = ~ref_clk_i;
    initial begin
        #200us;
        err_total++;
        report_and_stop;
    end
    // ----
    // read results, oldest note first
    // ----
    always @(posedge ref_clk_i) rdp <= (dacc_i && !dwr_i) || (xacc_i && !xwr_i);
    always @(negedge ref_clk_i) if (rdp) begin
        me = q.pop_front();
        if (me[9]) chk(xrdata_o, me[7:0]);
        else if (me[8]) chk(dbit_rd_o, me[0]);
        else chk(drdata_o, me[7:0]);
    end

    initial begin
        v = $urandom(41);
        repeat (4) @(posedge ref_clk_i);
        @(negedge ref_clk_i) rst_i = 0;
        #1 chk(fetch_addr_o, 16'h0000);
        rd(0, 0, 0, 8'h81, 10'h007);
        for (i = 2; i < 6; i++) rd(0, 0, 0, 8'(128 + i), 10'h000);
        rd(0, 0, 0, 8'hA2, 10'h000);
        for (i = 1; i < 6; i++) begin
            v = $urandom;
            acc(1, 0, 0, 0, 8'(128 + i), v);
            rd(0, 0, 0, 8'(128 + i), {2'b00, v});
        end
        acc(1, 0, 0, 0, 8'hA2, 8'hFF);
        rd(0, 0, 0, 8'hA2, 10'h017);
        acc(1, 0, 0, 0, 8'hA2, 8'h00);
        chk(trap_en_o, 1);
        acc(1, 0, 0, 0, 8'h82, 8'h20);
        acc(1, 0, 0, 0, 8'h83, 8'h50);
        xa(0, 0, {2'b10, 8'h7A});
        chk(data_pointer_o, 16'h5020);
        chk(ext_area_sel_o, 1);
        xa(1, 8'h33, 0);
        chk(ext_area_wr_o, 1);
        chk(xwdata_o, 8'h33);
        acc(1, 0, 0, 0, 8'h83, 8'h60);
        acc(1, 0, 0, 0, 8'h82, 8'h7F);
        xa(0, 0, {2'b10, 8'h80});
        chk(ee_sel_o, 1);
        xa(1, 8'h55, 0);
        chk(ext_area_wr_o, 0);
        idle;
        chk(ee_store_err_o, 1);
        acc(1, 0, 0, 0, 8'h83, 8'h70);
        xa(0, 0, {2'b10, 8'h00});
        // second pointer selected by extended operation code 1
        acc(1, 0, 0, 0, 8'h84, 8'h05);
        acc(1, 0, 0, 0, 8'h85, 8'h10);
        acc(1, 0, 0, 0, 8'hA2, 8'h01);
        xa(0, 0, {2'b10, 8'h5F});
        chk(data_pointer_o, 16'h1005);
        acc(1, 0, 0, 0, 8'hA2, 8'h00);
        for (i = 0; i < 4; i++) begin
            v = $urandom;
            acc(1, 0, 0, 0, 8'hD0, 8'(i * 8));
            acc(1, 0, 0, 1, 8'h05, v);
            chk(bank_sel_o, i[1:0]);
            rd(0, 0, 0, 8'(i * 8 + 5), {2'b00, v});
        end
        v = $urandom;
        acc(1, 1, 0, 0, 8'h90, v);
        chk({sfr_ext_sel_o, sfr_ext_wr_o}, 16'h0000);
        rd(0, 0, 0, 8'h90, 10'h000);
        acc(1, 0, 0, 0, 8'h90, 8'h11);
        chk({sfr_ext_sel_o, sfr_ext_wr_o}, 16'h0003);
        chk({sfr_ext_addr_o, sfr_ext_wdata_o}, 16'h9011);
        rd(1, 0, 0, 8'h90, {2'b00, v});
        acc(1, 0, 0, 0, 8'h30, ~v);
        rd(1, 0, 0, 8'h30, {2'b00, ~v});
        acc(1, 0, 0, 0, 8'h21, 8'h00);
        acc(1, 0, 1, 0, 8'h0A, 8'h01);
        rd(0, 0, 0, 8'h21, 10'h004);
        rd(0, 1, 0, 8'h0A, 10'h101);
        rd(0, 1, 0, 8'hD3, 10'h101);
        acc(1, 0, 1, 0, 8'hD4, 8'h00);
        v = $urandom;
        acc(1, 0, 0, 0, 8'h8E, v);
        chk(watchdog_data_wr_o, 1);
        chk(program_status_word_o, 8'h08);
        rd(0, 0, 0, 8'h8E, {2'b00, WCNT});
        chk(watchdog_data_reg_o, v);
        idle;
        pc_load_i = 1;
        pc_load_val_i = 16'h0FFF;
        idle;
        pc_inc_i = 1;
        chk(prog_addr_o, 12'hFFF);
        idle;
        chk(prog_sel_o, 0);
        for (i = 0; i < 16; i++) begin
            idle;
            irq_take_i = 1;
            irq_src_i = 4'(i);
            idle;
            pc_inc_i = 1;
            chk(fetch_addr_o, 16'(3 + 8 * i));
            idle;
            chk(fetch_addr_o, 16'(4 + 8 * i));
        end
        idle;
        idle;
        chk(q.size(), 0);
        report_and_stop;
    end
endmodule
